//--- verilog/tims_pkg.sv
// Constants and types shared by both ends of the interrupt signalling link
`default_nettype none
package tims_pkg;
  // Wired interrupt line positions
  localparam int NUM_IRQ = 11;
  localparam int IRQ_SECURE_EVTQ = 0;
  localparam int IRQ_NONSECURE_EVTQ = 1;
  localparam int IRQ_SECURE_SYNC_DONE = 2;
  localparam int IRQ_NONSECURE_SYNC_DONE = 3;
  localparam int IRQ_SECURE_GLOBAL = 4;
  localparam int IRQ_NONSECURE_GLOBAL = 5;
  localparam int IRQ_RAS_FAULT = 6;
  localparam int IRQ_RAS_RECOVERY = 7;
  localparam int IRQ_RAS_CRITICAL = 8;
  localparam int IRQ_PERF_MONITOR = 9;
  localparam int IRQ_PAGE_REQUEST_QUEUE = 10;
  // Lines 0 to NUM_MSI_SRC-1 may also travel as messages
  localparam int NUM_MSI_SRC = 6;
  localparam int NUM_WIRED_ONLY = NUM_IRQ - NUM_MSI_SRC;

  // Message word layout
  localparam int MSI_DATA_W = 64;
  localparam int MSI_SRC_LSB = 0;
  localparam int MSI_SRC_W = 8;
  localparam int MSI_SEQ_LSB = 8;
  localparam int MSI_SEQ_W = 8;
  localparam int MSI_TARGET_LSB = 32;
  localparam int MSI_TARGET_W = 32;

  // Buffering and flow control
  localparam int FIFO_DEPTH = 16;
  localparam int OUTST_W = 4;
  localparam logic [OUTST_W-1:0] OUTST_MAX = 4'hF;

  // Reset values
  localparam logic [NUM_IRQ-1:0] RST_IRQ = 11'h000;
  localparam logic [NUM_MSI_SRC-1:0] RST_MSI_PEND = 6'h00;
  localparam logic [MSI_SEQ_W-1:0] RST_SEQ = 8'h00;
  localparam logic [OUTST_W-1:0] RST_OUTST = 4'h0;

  typedef logic [MSI_DATA_W-1:0] tims_word_t;
  typedef logic [NUM_IRQ-1:0] tims_irq_t;
endpackage : tims_pkg
`default_nettype wire

//--- verilog/tims_link_if.sv
// Wired interrupt lines and message link between the unit and the controller
`timescale 1ns/1ps
`default_nettype none
interface tims_link_if;
  tims_pkg::tims_irq_t wired_irq;
  logic msi_tvalid;
  logic msi_tready;
  tims_pkg::tims_word_t msi_tdata;
  logic msi_twakeup;
  logic rsp_tvalid;
  logic rsp_tready;
  logic rsp_twakeup;

  modport unit (
    output wired_irq,
    output msi_tvalid,
    input msi_tready,
    output msi_tdata,
    output msi_twakeup,
    input rsp_tvalid,
    output rsp_tready,
    input rsp_twakeup
  );

  modport ctrl (
    input wired_irq,
    input msi_tvalid,
    output msi_tready,
    input msi_tdata,
    input msi_twakeup,
    output rsp_tvalid,
    input rsp_tready,
    output rsp_twakeup
  );
endinterface : tims_link_if
`default_nettype wire

//--- verilog/tims_unit_end.sv
// Translation control unit end: wired edge interrupts and message delivery
//
// Function
// - Wired outputs signal each interrupt as rising edge
// - Controller registers every low-to-high wired transition
// - Capable interrupts go as messages, wires, or both
// - Message-capturing system may leave those wires open
// - Event queue interrupts per domain, pending or overflow
// - Sync completion interrupt per security domain
// - Separate global error interrupts per domain
// - Three reliability outputs: fault, recovery, critical
// - Performance monitor interrupt is never sent as message
// - Page request queue interrupt output provided
// - Messages are 64-bit words on valid/ready stream
// - Each side drives its own wakeup signal
// - Controller reports acceptance; unit takes each response
`timescale 1ns/1ps
`default_nettype none

module tims_fifo #(
  parameter int WIDTH = tims_pkg::MSI_DATA_W,
  parameter int DEPTH = tims_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != CNT_W'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Head entry only changes on a pop, so a waiting word stays put
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule : tims_fifo

module tims_unit_end (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  tims_link_if.unit LINK,
  input wire logic [tims_pkg::NUM_IRQ-1:0] COND_IN,
  input wire logic [tims_pkg::NUM_MSI_SRC-1:0] WIRED_ENABLE,
  input wire logic [tims_pkg::NUM_MSI_SRC-1:0] MSI_ENABLE,
  input wire logic [tims_pkg::MSI_TARGET_W-1:0] MSI_TARGET,
  output logic MSI_ACCEPTED,
  output logic [tims_pkg::OUTST_W-1:0] MSI_OUTSTANDING,
  output logic MSI_FIFO_FULL
);
  localparam int N = tims_pkg::NUM_IRQ;
  localparam int M = tims_pkg::NUM_MSI_SRC;

  logic [N-1:0] cond_q;
  logic [N-1:0] cond_rise;
  logic [N-1:0] wire_en;
  logic [N-1:0] wired_irq;
  logic [M-1:0] msi_pend;
  logic [M-1:0] grant;
  logic [tims_pkg::MSI_SRC_W-1:0] grant_src;
  logic [tims_pkg::MSI_SEQ_W-1:0] seq;
  tims_pkg::tims_word_t push_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  tims_pkg::tims_word_t fifo_out_data;
  logic [tims_pkg::OUTST_W-1:0] outst;
  logic room;
  logic sent;
  logic rsp_taken;
  logic rsp_ready;

  // Condition inputs are levels from the queue logic on this clock
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cond_q <= tims_pkg::RST_IRQ;
    end else begin
      cond_q <= COND_IN;
    end
  end

  // Wired-only lines: reliability, performance monitor, page request
  // Reliability lines always wired
  assign wire_en = {{tims_pkg::NUM_WIRED_ONLY{1'b1}}, WIRED_ENABLE};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_line
      // Each new condition is an event
      assign cond_rise[gi] = COND_IN[gi] & ~cond_q[gi];
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          wired_irq[gi] <= 1'b0;
        end else begin
          wired_irq[gi] <= cond_rise[gi] & wire_en[gi];
        end
      end
    end
  endgenerate

  // Sync, global, reliability and page lines share the path
  assign LINK.wired_irq = wired_irq;

  generate
    for (gi = 0; gi < M; gi++) begin : g_msi
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          msi_pend[gi] <= 1'b0;
        end else begin
          msi_pend[gi] <= (cond_rise[gi] & MSI_ENABLE[gi]) | (msi_pend[gi] & ~grant[gi]);
        end
      end
    end
  endgenerate

  always_comb begin
    grant = '0;
    grant_src = '0;
    for (int i = M - 1; i >= 0; i--) begin
      if (msi_pend[i] && fifo_in_ready) begin
        grant = '0;
        grant[i] = 1'b1;
        grant_src = tims_pkg::MSI_SRC_W'(i);
      end
    end
  end

  always_comb begin
    push_word = '0;
    push_word[tims_pkg::MSI_SRC_LSB +: tims_pkg::MSI_SRC_W] = grant_src;
    push_word[tims_pkg::MSI_SEQ_LSB +: tims_pkg::MSI_SEQ_W] = seq;
    push_word[tims_pkg::MSI_TARGET_LSB +: tims_pkg::MSI_TARGET_W] = MSI_TARGET;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq <= tims_pkg::RST_SEQ;
    end else if (|grant) begin
      seq <= seq + 1'b1;
    end
  end

  tims_fifo #(
    .WIDTH(tims_pkg::MSI_DATA_W),
    .DEPTH(tims_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .in_valid(|grant),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Cap on unanswered messages; room only shrinks on a handshake
  assign room = (outst != tims_pkg::OUTST_MAX);
  assign LINK.msi_tvalid = fifo_out_valid & room;
  assign LINK.msi_tdata = fifo_out_data;
  assign sent = LINK.msi_tvalid & LINK.msi_tready;
  assign fifo_out_ready = LINK.msi_tready & room;

  // Response taken on valid and ready
  assign rsp_taken = LINK.rsp_tvalid & rsp_ready;
  assign LINK.rsp_tready = rsp_ready;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rsp_ready <= 1'b0;
    end else begin
      rsp_ready <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      outst <= tims_pkg::RST_OUTST;
    end else if (sent && !rsp_taken) begin
      outst <= outst + 1'b1;
    end else if (rsp_taken && !sent && outst != '0) begin
      outst <= outst - 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MSI_ACCEPTED <= 1'b0;
    end else begin
      MSI_ACCEPTED <= rsp_taken;
    end
  end

  // Outbound wakeup while any message is in flight
  assign LINK.msi_twakeup = (|msi_pend) | fifo_out_valid | (outst != '0);
  assign MSI_OUTSTANDING = outst;
  assign MSI_FIFO_FULL = ~fifo_in_ready;
endmodule : tims_unit_end
`default_nettype wire

//--- verilog/tims_ctrl_end.sv
// Interrupt controller end: edge capture of wired lines and message intake
`timescale 1ns/1ps
`default_nettype none
module tims_ctrl_end (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  tims_link_if.ctrl LINK,
  input wire logic ACCEPT_ENABLE,
  input wire logic [tims_pkg::NUM_IRQ-1:0] IRQ_CLEAR,
  output logic [tims_pkg::NUM_IRQ-1:0] IRQ_PENDING,
  output logic MSI_STROBE,
  output tims_pkg::tims_word_t MSI_WORD
);
  localparam int N = tims_pkg::NUM_IRQ;

  logic [N-1:0] wired_q;
  logic [N-1:0] wired_edge;
  logic [N-1:0] msi_set;
  logic [tims_pkg::MSI_SRC_W-1:0] msi_src;
  logic [tims_pkg::OUTST_W-1:0] rsp_cnt;
  logic accept;
  logic rsp_sent;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wired_q <= tims_pkg::RST_IRQ;
    end else begin
      wired_q <= LINK.wired_irq;
    end
  end

  assign wired_edge = LINK.wired_irq & ~wired_q;

  // Word taken on valid and ready
  assign LINK.msi_tready = ACCEPT_ENABLE & (rsp_cnt != tims_pkg::OUTST_MAX);
  assign accept = LINK.msi_tvalid & LINK.msi_tready;
  assign msi_src = LINK.msi_tdata[tims_pkg::MSI_SRC_LSB +: tims_pkg::MSI_SRC_W];

  // Message sets same pending bit as wire
  always_comb begin
    msi_set = '0;
    for (int i = 0; i < tims_pkg::NUM_MSI_SRC; i++) begin
      if (accept && msi_src == tims_pkg::MSI_SRC_W'(i)) begin
        msi_set[i] = 1'b1;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_PENDING <= tims_pkg::RST_IRQ;
    end else begin
      IRQ_PENDING <= (IRQ_PENDING & ~IRQ_CLEAR) | wired_edge | msi_set;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MSI_STROBE <= 1'b0;
      MSI_WORD <= '0;
    end else begin
      MSI_STROBE <= accept;
      if (accept) begin
        MSI_WORD <= LINK.msi_tdata;
      end
    end
  end

  assign LINK.rsp_tvalid = (rsp_cnt != '0);
  assign rsp_sent = LINK.rsp_tvalid & LINK.rsp_tready;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rsp_cnt <= tims_pkg::RST_OUTST;
    end else if (accept && !rsp_sent) begin
      rsp_cnt <= rsp_cnt + 1'b1;
    end else if (rsp_sent && !accept) begin
      rsp_cnt <= rsp_cnt - 1'b1;
    end
  end

  // Response wakeup while responses are owed
  assign LINK.rsp_twakeup = (rsp_cnt != '0);
endmodule : tims_ctrl_end
`default_nettype wire

//--- tb/tims_link_chk.sv
// Checker on the wired lines and message link between the two ends
`timescale 1ns/1ps
`default_nettype none
module tims_link_chk (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire tims_pkg::tims_irq_t wired_irq,
  input wire logic msi_tvalid,
  input wire logic msi_tready,
  input wire tims_pkg::tims_word_t msi_tdata,
  input wire logic msi_twakeup,
  input wire logic rsp_tvalid,
  input wire logic rsp_tready,
  input wire logic rsp_twakeup
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_word_hs; msi_tvalid && msi_tready; endsequence
  sequence s_word_wait; msi_tvalid && !msi_tready; endsequence
  property p_wire_edge; (wired_irq & $past(wired_irq)) == 11'h000; endproperty
  property p_hold; s_word_wait |=> msi_tvalid && $stable(msi_tdata); endproperty
  property p_unit_wake; msi_tvalid |-> msi_twakeup; endproperty
  property p_ctrl_wake; rsp_tvalid |-> rsp_twakeup; endproperty
  property p_resp; s_word_hs |=> rsp_tvalid; endproperty
  property p_rsp_ready; rsp_tvalid |-> rsp_tready; endproperty
  property p_rsp_cause; $rose(rsp_tvalid) |-> $past(msi_tvalid && msi_tready); endproperty
  property p_word; msi_tvalid |-> msi_tdata[7:0] < 8'h06 && msi_tdata[31:16] == 16'h0000;
  endproperty
  a_wire_edge: assert property (p_wire_edge) else $error("wired pulse too long");
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  a_unit_wake: assert property (p_unit_wake) else $error("unit wakeup low");
  a_ctrl_wake: assert property (p_ctrl_wake) else $error("ctrl wakeup low");
  a_resp: assert property (p_resp) else $error("no response after word");
  a_rsp_ready: assert property (p_rsp_ready) else $error("response not taken");
  a_rsp_cause: assert property (p_rsp_cause) else $error("response without word");
  a_word: assert property (p_word) else $error("bad word source");
endmodule : tims_link_chk
`default_nettype wire

//--- tb/test_translation_irq_msi_out.sv
// Self-checking bench for both ends of the interrupt signalling link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t %s", $time, m); end end
module test_translation_irq_msi_out;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  tims_pkg::tims_irq_t cond_in = 11'h000;
  tims_pkg::tims_irq_t irq_clear = 11'h000;
  tims_pkg::tims_irq_t irq_pending;
  logic [5:0] wired_en = 6'h3F;
  logic [5:0] msi_en = 6'h00;
  logic [31:0] target = 32'h00000000;
  logic accept_en = 1'b1;
  logic msi_strobe;
  logic msi_accepted;
  logic fifo_full;
  logic [3:0] outst;
  logic [7:0] seq = 8'h00;
  tims_pkg::tims_word_t msi_word;
  tims_pkg::tims_word_t exp_q[$];
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int sent = 0;
  int accepted = 0;
  int seed = 32'h5f42e20e;
  tims_link_if link ();
  always #10 core_clk = ~core_clk;
  tims_unit_end tims_unit_end_inst (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(link),
    .COND_IN(cond_in), .WIRED_ENABLE(wired_en), .MSI_ENABLE(msi_en), .MSI_TARGET(target),
    .MSI_ACCEPTED(msi_accepted), .MSI_OUTSTANDING(outst), .MSI_FIFO_FULL(fifo_full));
  tims_ctrl_end tims_ctrl_end_inst (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(link),
    .ACCEPT_ENABLE(accept_en), .IRQ_CLEAR(irq_clear), .IRQ_PENDING(irq_pending),
    .MSI_STROBE(msi_strobe), .MSI_WORD(msi_word));
  tims_link_chk tims_link_chk_inst (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .wired_irq(link.wired_irq), .msi_tvalid(link.msi_tvalid), .msi_tready(link.msi_tready),
    .msi_tdata(link.msi_tdata), .msi_twakeup(link.msi_twakeup), .rsp_tvalid(link.rsp_tvalid),
    .rsp_tready(link.rsp_tready), .rsp_twakeup(link.rsp_twakeup));

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // One rise on a line; the model queues the word it should produce
  task automatic fire(input int i, input logic exp_wire);
    int pulses;
    pulses = 0;
    cond_in[i] = 1'b1;
    if (i < 6 && msi_en[i]) begin
      exp_q.push_back({target, 16'h0000, seq, i[7:0]});
      seq++;
      sent++;
    end
    repeat (4) begin
      @(negedge core_clk);
      cond_in[i] = 1'b0;
      if (link.wired_irq[i] === 1'b1) pulses++;
    end
    `CHK(pulses, exp_wire ? 1 : 0, "wired pulse count")
  endtask : fire

  always @(negedge core_clk) begin
    if (msi_strobe === 1'b1) begin
      `CHK(msi_word, exp_q.size() > 0 ? exp_q.pop_front() : 'x, "message word")
    end
    if (msi_accepted === 1'b1) accepted++;
    cycles++;
    // Whole run needs well under 2000 cycles
    if (cycles == 2000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    for (int k = 0; k < 33; k++) begin
      wired_en = 6'($random(seed));
      msi_en = 6'($random(seed));
      target = $random(seed);
      fire(k % 11, k % 11 >= 6 || wired_en[k % 11]);
      repeat (6) @(negedge core_clk);
      `CHK(irq_pending[k % 11], k % 11 >= 6 || wired_en[k % 11] || msi_en[k % 11], "pending")
      irq_clear = 11'h7FF;
      @(negedge core_clk);
      irq_clear = 11'h000;
      `CHK(irq_pending, 11'h000, "pending cleared")
    end
    $display("test lines done");
    // Stall the controller so words pile up in the buffer
    accept_en = 1'b0;
    wired_en = 6'h00;
    msi_en = 6'h3F;
    for (int k = 0; k < 17; k++) fire(k % 6, 1'b0);
    `CHK(fifo_full, 1'b1, "buffer full")
    `CHK(link.msi_tvalid, 1'b1, "valid held")
    accept_en = 1'b1;
    repeat (120) @(negedge core_clk);
    `CHK(exp_q.size(), 0, "all words delivered")
    `CHK(accepted, sent, "responses")
    `CHK(outst, 4'h0, "nothing outstanding")
    `CHK(fifo_full, 1'b0, "buffer drained")
    `CHK(link.msi_twakeup, 1'b0, "wakeup idle")
    $display("test buffer done");
    give_verdict();
  end
endmodule : test_translation_irq_msi_out
`default_nettype wire
